// ### logic/mocr_pkg.sv
// Purpose: shared constants and types of the modem offset and auxiliary control registers
// Assumes: 8-bit address then 8-bit data per serial frame, MSB first
// Notes:   the address codes are simply the register numbers
package mocr_pkg;

    localparam int          MOCR_DATA_W      = 8;
    localparam int          MOCR_ADDR_W      = 8;
    localparam int          MOCR_FRAME_BITS  = MOCR_ADDR_W + MOCR_DATA_W;
    localparam int          MOCR_CNT_W       = 5;

    // register addresses on the serial control port
    localparam logic [7:0]  MOCR_ADDR_I_NEG  = 8'h03;
    localparam logic [7:0]  MOCR_ADDR_Q_NEG  = 8'h04;
    localparam logic [7:0]  MOCR_ADDR_AUX    = 8'h05;

    localparam logic [7:0]  MOCR_RESET_VAL   = 8'h00;

    // field positions
    localparam int          MOCR_OFS_MSB     = 7;
    localparam int          MOCR_OFS_LSB     = 3;
    localparam int          MOCR_OFS_W       = MOCR_OFS_MSB - MOCR_OFS_LSB + 1;
    localparam int          MOCR_AUX_BURST   = 7;
    localparam int          MOCR_AUX_TST_MSB = 6;
    localparam int          MOCR_AUX_TST_LSB = 4;
    localparam int          MOCR_AUX_INV1    = 3;
    localparam int          MOCR_AUX_INV0    = 2;
    localparam int          MOCR_AUX_SHAPE   = 1;
    localparam int          MOCR_AUX_HOLD    = 0;

    // offset step and decoded width
    localparam int          MOCR_STEP_MV     = 3;
    localparam int          MOCR_MV_W        = 8;

    typedef struct packed {
        logic       burst_window_out_enable;
        logic [2:0] device_test_bits;
        logic       local_invert_select1;
        logic       local_invert_select0;
        logic       clock_shaping_select;
        logic       osc_pin_power_hold;
    } mocr_aux_t;

    typedef struct packed {
        logic [MOCR_OFS_W-1:0] i_offset_code;
        logic [MOCR_OFS_W-1:0] q_offset_code;
        mocr_aux_t             aux;
    } mocr_regs_t;

endpackage

// ### logic/mocr_sync.sv
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module mocr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // refused at elaboration, not at run time
    if (WIDTH < 1) begin : g_width_check
        $error("mocr_sync: WIDTH must be at least 1");
    end

    always_comb begin
        meta_d = ce ? async_in : meta_q;
        sync_d = ce ? meta_q : sync_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

// ### logic/mocr_regs.sv
// Purpose: offset code and auxiliary control registers written over the serial control port
// Assumes: serial pins and power-down pin are asynchronous to MCLK; mode inputs are on MCLK
// Notes:   registers are write-only; all outputs registered
`timescale 1ns/1ps
// Functional notes
// - I offset code in bits 7..3
// - Q offset code taken from bits 7..3
// - code decodes to signed 3 mV steps
// - aux bit 7 selects burst window output
// - bits 3,2 select local inverting mode
// - bit 1 selects clock pulse shaping mode
// - bit 0 holds oscillator pins powered, only with clock shaping mode (bit 1) selected
// - power-down input clears all registers
// - burst output needs internal clock loop selected
module mocr_regs
    import mocr_pkg::*;
(
    input  wire logic                    MCLK,
    input  wire logic                    RST_B,
    input  wire logic                    CE,
    input  wire logic                    POWER_DOWN_INPUT,
    input  wire logic                    WHOLE_POWER_DOWN,
    input  wire logic                    SER_ENABLE_B,
    input  wire logic                    SER_CLK,
    input  wire logic                    SER_DATA_IN,
    input  wire logic                    TX_CLOCK_SELECT,
    input  wire logic                    TX_CLK_384K,
    input  wire logic                    BURST_WINDOW,
    output logic                         TX_CLOCK_OUT,
    output logic        [MOCR_OFS_W-1:0] I_OFFSET_CODE,
    output logic        [MOCR_OFS_W-1:0] Q_OFFSET_CODE,
    output logic signed [MOCR_MV_W-1:0]  I_OFFSET_MV,
    output logic signed [MOCR_MV_W-1:0]  Q_OFFSET_MV,
    output logic        [2:0]            DEVICE_TEST_BITS,
    output logic                         LOCAL_INVERT_SELECT,
    output logic                         LOCAL_MODE_UNDEFINED,
    output logic                         CLOCK_SHAPING_SELECT,
    output logic                         OSC_PIN_POWER_ON
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    logic [3:0]                 pins_sync;
    logic                       pd_s;
    logic                       en_act_s;
    logic                       en_b_s;
    logic                       sclk_s;
    logic                       sdin_s;

    // enable synced inverted: flop reset value then matches the idle pin, no false frame start
    mocr_sync #(.WIDTH(4)) mocr_sync_i (
        .clk      (MCLK),
        .rst_b    (RST_B),
        .ce       (CE),
        .async_in ({POWER_DOWN_INPUT, ~SER_ENABLE_B, SER_CLK, SER_DATA_IN}),
        .sync_out (pins_sync)
    );
    assign {pd_s, en_act_s, sclk_s, sdin_s} = pins_sync;
    assign en_b_s = ~en_act_s;

    // serial deframer state
    logic                       sclk_prev_q,  sclk_prev_d;
    logic                       en_b_prev_q,  en_b_prev_d;
    logic [MOCR_FRAME_BITS-1:0] shift_q,      shift_d;
    logic [MOCR_CNT_W-1:0]      cnt_q,        cnt_d;
    logic                       wr_stb;
    logic [MOCR_ADDR_W-1:0]     wr_addr;
    logic [MOCR_DATA_W-1:0]     wr_data;

    always_comb begin
        sclk_prev_d = sclk_s;
        en_b_prev_d = en_b_s;
        shift_d     = shift_q;
        cnt_d       = cnt_q;
        if (en_b_s) begin
            cnt_d = '0;
        end else if (sclk_s && !sclk_prev_q && cnt_q != MOCR_CNT_W'(MOCR_FRAME_BITS)) begin
            shift_d = {shift_q[MOCR_FRAME_BITS-2:0], sdin_s};
            cnt_d   = cnt_q + MOCR_CNT_W'(1);
        end
        // a frame commits on the release of enable, and only if it is whole
        wr_stb  = en_b_s && !en_b_prev_q && cnt_q == MOCR_CNT_W'(MOCR_FRAME_BITS);
        wr_addr = shift_q[MOCR_FRAME_BITS-1:MOCR_DATA_W];
        wr_data = shift_q[MOCR_DATA_W-1:0];
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            sclk_prev_q <= 1'b0;
            en_b_prev_q <= 1'b1;
            shift_q     <= '0;
            cnt_q       <= '0;
        end else if (CE) begin
            sclk_prev_q <= sclk_prev_d;
            en_b_prev_q <= en_b_prev_d;
            shift_q     <= shift_d;
            cnt_q       <= cnt_d;
        end
    end

    // register file
    mocr_regs_t regs_q, regs_d;

    always_comb begin
        regs_d = regs_q;
        if (pd_s) begin
            regs_d = mocr_regs_t'({MOCR_RESET_VAL[MOCR_OFS_W-1:0], MOCR_RESET_VAL[MOCR_OFS_W-1:0],
                                   MOCR_RESET_VAL});
        end else if (wr_stb) begin
            unique case (wr_addr)
                MOCR_ADDR_I_NEG: begin
                    regs_d.i_offset_code = wr_data[MOCR_OFS_MSB:MOCR_OFS_LSB];
                end
                MOCR_ADDR_Q_NEG: begin
                    // the field table wins over the four-bit wording
                    regs_d.q_offset_code = wr_data[MOCR_OFS_MSB:MOCR_OFS_LSB];
                end
                MOCR_ADDR_AUX: begin
                    regs_d.aux = mocr_aux_t'(wr_data);
                end
                default: begin
                    regs_d = regs_q;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            regs_q <= '0;
        end else if (CE) begin
            regs_q <= regs_d;
        end
    end

    // output stage
    logic                        tx_out_q,  tx_out_d;
    logic signed [MOCR_MV_W-1:0] i_mv_q,    i_mv_d;
    logic signed [MOCR_MV_W-1:0] q_mv_q,    q_mv_d;
    logic                        inv_q,     inv_d;
    logic                        undef_q,   undef_d;
    logic                        osc_on_q,  osc_on_d;

    always_comb begin
        // burst window only with the internal clock loop in use
        if (regs_q.aux.burst_window_out_enable && !TX_CLOCK_SELECT) begin
            tx_out_d = BURST_WINDOW;
        end else begin
            tx_out_d = TX_CLK_384K;
        end
        // code is two's complement: 10000 is -16 steps
        i_mv_d = MOCR_MV_W'($signed(regs_q.i_offset_code) * MOCR_STEP_MV);
        q_mv_d = MOCR_MV_W'($signed(regs_q.q_offset_code) * MOCR_STEP_MV);
        // mixed bit pairs are undefined; flagged, treated as normal
        inv_d   = regs_q.aux.local_invert_select1 & regs_q.aux.local_invert_select0;
        undef_d = regs_q.aux.local_invert_select1 ^ regs_q.aux.local_invert_select0;
        // hold keeps pins alive through whole-device power-down in shaping mode
        osc_on_d = !WHOLE_POWER_DOWN ||
                   (regs_q.aux.clock_shaping_select && regs_q.aux.osc_pin_power_hold);
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            tx_out_q <= 1'b0;
            i_mv_q   <= '0;
            q_mv_q   <= '0;
            inv_q    <= 1'b0;
            undef_q  <= 1'b0;
            osc_on_q <= 1'b0;
        end else if (CE) begin
            tx_out_q <= tx_out_d;
            i_mv_q   <= i_mv_d;
            q_mv_q   <= q_mv_d;
            inv_q    <= inv_d;
            undef_q  <= undef_d;
            osc_on_q <= osc_on_d;
        end
    end

    assign TX_CLOCK_OUT         = tx_out_q;
    assign I_OFFSET_CODE        = regs_q.i_offset_code;
    assign Q_OFFSET_CODE        = regs_q.q_offset_code;
    assign I_OFFSET_MV          = i_mv_q;
    assign Q_OFFSET_MV          = q_mv_q;
    assign DEVICE_TEST_BITS     = regs_q.aux.device_test_bits;
    assign LOCAL_INVERT_SELECT  = inv_q;
    assign LOCAL_MODE_UNDEFINED = undef_q;
    assign CLOCK_SHAPING_SELECT = regs_q.aux.clock_shaping_select;
    assign OSC_PIN_POWER_ON     = osc_on_q;

    AST_I_WRITE: assert property (CE && !pd_s && wr_stb && wr_addr == MOCR_ADDR_I_NEG
        |=> I_OFFSET_CODE == $past(wr_data[MOCR_OFS_MSB:MOCR_OFS_LSB]))
        else $error("I offset code not loaded from bits 7..3");
    AST_Q_WRITE: assert property (CE && !pd_s && wr_stb && wr_addr == MOCR_ADDR_Q_NEG
        |=> Q_OFFSET_CODE == $past(wr_data[MOCR_OFS_MSB:MOCR_OFS_LSB]))
        else $error("Q offset code not loaded from bits 7..3");
    AST_I_MV: assert property (CE |=> I_OFFSET_MV ==
        MOCR_MV_W'($signed($past(I_OFFSET_CODE)) * MOCR_STEP_MV))
        else $error("I offset millivolt decode wrong");
    AST_Q_MIN: assert property (CE && Q_OFFSET_CODE == 5'h10 |=> Q_OFFSET_MV == -8'sd48)
        else $error("Q code 10000 must decode to -48 mV");
    AST_TX_BURST: assert property (CE && regs_q.aux.burst_window_out_enable && !TX_CLOCK_SELECT
        |=> TX_CLOCK_OUT == $past(BURST_WINDOW))
        else $error("burst window not routed to transmit clock output");
    AST_TX_CLK: assert property (CE && (!regs_q.aux.burst_window_out_enable || TX_CLOCK_SELECT)
        |=> TX_CLOCK_OUT == $past(TX_CLK_384K))
        else $error("transmit clock not routed to transmit clock output");
    AST_INVERT: assert property (CE && regs_q.aux.local_invert_select1 && regs_q.aux.local_invert_select0
        |=> LOCAL_INVERT_SELECT && !LOCAL_MODE_UNDEFINED)
        else $error("local inverting mode not selected");
    AST_NORMAL_MODE: assert property (CE && !regs_q.aux.local_invert_select1
        && !regs_q.aux.local_invert_select0 |=> !LOCAL_INVERT_SELECT && !LOCAL_MODE_UNDEFINED)
        else $error("normal mode not selected");
    AST_OSC_AWAKE: assert property (CE && !WHOLE_POWER_DOWN |=> OSC_PIN_POWER_ON)
        else $error("oscillator pins off outside whole power-down");
    AST_OSC_HOLD: assert property (CE && WHOLE_POWER_DOWN && CLOCK_SHAPING_SELECT
        && regs_q.aux.osc_pin_power_hold |=> OSC_PIN_POWER_ON)
        else $error("oscillator pins powered down despite hold");
    AST_OSC_DOWN: assert property (CE && WHOLE_POWER_DOWN && !regs_q.aux.osc_pin_power_hold
        |=> !OSC_PIN_POWER_ON)
        else $error("oscillator pins stay on in whole power-down");
    AST_OSC_MODE: assert property (CE && WHOLE_POWER_DOWN && !CLOCK_SHAPING_SELECT
        |=> !OSC_PIN_POWER_ON)
        else $error("oscillator circuit mode kept pins on in whole power-down");
    AST_IGNORE_ADDR: assert property (CE && !pd_s && wr_stb && wr_addr != MOCR_ADDR_I_NEG
        && wr_addr != MOCR_ADDR_Q_NEG && wr_addr != MOCR_ADDR_AUX |=> $stable(regs_q))
        else $error("write to unknown address changed a register");
    AST_PD_CLEAR: assert property (CE && pd_s |=> regs_q == '0)
        else $error("power-down did not clear registers");
endmodule

// ### sim/mocr_host.sv
// Purpose: serial control port host model for the offset and auxiliary registers
// Assumes: 8 address bits then 8 data bits, MSB first, commit on enable release
// Notes:   phases last 4 clock cycles, three more than the port needs
`timescale 1ns/1ps
module mocr_host (
    input  wire logic clk,
    output logic      ser_enable_b,
    output logic      ser_clk,
    output logic      ser_data
);
    initial begin
        ser_enable_b = 1'b1;
        ser_clk = 1'b0;
        ser_data = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    // fewer than 16 bits gives a frame the port must drop
    task automatic send(input logic [15:0] frame, input int nbits);
        ser_enable_b <= 1'b0;
        for (int k = 0; k < nbits; k++) begin
            ser_data <= frame[15-k];
            hold(4);
            ser_clk <= 1'b1;
            hold(4);
            ser_clk <= 1'b0;
        end
        hold(4);
        ser_enable_b <= 1'b1;
        // released data line must not keep showing the last bit
        ser_data <= ~ser_data;
        hold(4);
    endtask
endmodule

// ### sim/modem_offset_and_aux_control_regs_tb_top.sv
// Purpose: self-checking bench of the offset and auxiliary control registers
// Assumes: host model drives the serial port; other inputs are driven here
// Notes:   notes queue is popped by the output watcher on the falling edge
`timescale 1ns/1ps
module modem_offset_and_aux_control_regs_tb_top
    import mocr_pkg::*;
;
    logic              mclk = 1'b0;
    logic              rst_b = 1'b0;
    logic              ce = 1'b1;
    logic              pd = 1'b0;
    logic              whole_pd = 1'b0;
    logic              tx_sel = 1'b0;
    logic              clk384 = 1'b0;
    logic              bw = 1'b0;
    logic              tx_chk = 1'b0;
    logic              exp_tx = 1'b0;
    logic              en_b, sclk, sdat, tx_out, li, lu, cs, op;
    logic [4:0]        ic, qc, c;
    logic signed [7:0] imv, qmv;
    logic [2:0]        tst;
    logic [7:0]        i_m = 8'h00, q_m = 8'h00, a_m = 8'h00;
    logic [4:0]        tbl [4] = '{5'h00, 5'h0f, 5'h10, 5'h1f};
    logic [32:0]       notes [$];
    int                errors = 0;
    int                samples_checked = 0;
    int                cycles = 0;

    always #2.5 mclk = ~mclk;

    mocr_regs mocr_regs_i (
        .MCLK(mclk), .RST_B(rst_b), .CE(ce), .POWER_DOWN_INPUT(pd), .WHOLE_POWER_DOWN(whole_pd),
        .SER_ENABLE_B(en_b), .SER_CLK(sclk), .SER_DATA_IN(sdat), .TX_CLOCK_SELECT(tx_sel),
        .TX_CLK_384K(clk384), .BURST_WINDOW(bw), .TX_CLOCK_OUT(tx_out), .I_OFFSET_CODE(ic),
        .Q_OFFSET_CODE(qc), .I_OFFSET_MV(imv), .Q_OFFSET_MV(qmv), .DEVICE_TEST_BITS(tst),
        .LOCAL_INVERT_SELECT(li), .LOCAL_MODE_UNDEFINED(lu), .CLOCK_SHAPING_SELECT(cs),
        .OSC_PIN_POWER_ON(op)
    );
    mocr_host mocr_host_i (.clk(mclk), .ser_enable_b(en_b), .ser_clk(sclk), .ser_data(sdat));

    function automatic logic signed [7:0] mv(input logic [4:0] code);
        logic signed [7:0] v;
        v = {{3{code[4]}}, code};
        return v * 8'sd3;
    endfunction

    function automatic logic [32:0] exp_v();
        return {i_m[7:3], q_m[7:3], mv(i_m[7:3]), mv(q_m[7:3]), a_m[6:4], a_m[3] & a_m[2],
                a_m[3] ^ a_m[2], a_m[1], ~whole_pd | (a_m[1] & a_m[0])};
    endfunction

    task automatic cmp(input logic [32:0] got, input logic [32:0] want);
        samples_checked++;
        if (got !== want) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic note();
        repeat (3) @(posedge mclk);
        notes.push_back(exp_v());
        tx_chk <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tx_chk <= 1'b0;
        mocr_host_i.send({a, d}, 16);
        if (a == MOCR_ADDR_I_NEG) i_m = d;
        if (a == MOCR_ADDR_Q_NEG) q_m = d;
        if (a == MOCR_ADDR_AUX) a_m = d;
        note();
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // expectation from the values sampled at this edge, one cycle of lag
    always @(posedge mclk) begin
        exp_tx <= (a_m[MOCR_AUX_BURST] && !tx_sel) ? bw : clk384;
        clk384 <= 1'($urandom);
        bw <= 1'($urandom);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end

    always @(negedge mclk) begin
        if (notes.size() > 0) begin
            cmp({ic, qc, imv, qmv, tst, li, lu, cs, op}, notes.pop_front());
        end
        if (tx_chk) begin
            cmp({32'h0, tx_out}, {32'h0, exp_tx});
        end
    end

    initial begin
        void'($urandom(8));
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        note();
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            c = (k < 4) ? tbl[k] : 5'($urandom);
            wr(MOCR_ADDR_I_NEG, {c, 3'($urandom)});
            // mirror of the table so the Q side reaches 10000 and 01111 too
            wr(MOCR_ADDR_Q_NEG, {c ^ 5'h1f, 3'($urandom)});
        end
        $display("test offset codes done");
        for (int k = 0; k < 32; k++) begin
            whole_pd <= k[4];
            tx_sel <= k[3] ^ k[1];
            // test bits kept zero as the host must
            wr(MOCR_ADDR_AUX, {k[4] ^ k[0], 3'b000, 4'(k)});
        end
        whole_pd <= ~whole_pd;
        note();
        $display("test aux modes done");
        mocr_host_i.send({MOCR_ADDR_I_NEG, 8'h5a}, 15);
        note();
        wr(8'h07, 8'hff);
        $display("test refused frames done");
        wr(MOCR_ADDR_AUX, 8'h8f);
        // with the clock enable low a power-down pulse must go unseen
        tx_chk <= 1'b0;
        ce <= 1'b0;
        pd <= 1'b1;
        repeat (6) @(posedge mclk);
        pd <= 1'b0;
        ce <= 1'b1;
        note();
        $display("test clock enable freeze done");
        tx_chk <= 1'b0;
        pd <= 1'b1;
        repeat (6) @(posedge mclk);
        pd <= 1'b0;
        {i_m, q_m, a_m} = '0;
        note();
        $display("test power down clear done");
        wr(MOCR_ADDR_Q_NEG, 8'hff);
        tx_chk <= 1'b0;
        rst_b <= 1'b0;
        {i_m, q_m, a_m} = '0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        note();
        $display("test second reset done");
        summarize();
    end
endmodule
